/* File: src/lmrl_pkg.sv */
// Purpose: Shared constants for the serial display RAM loader and output mapper.
// Assumes: One 40 x 8 display RAM and forty output pins.
// Notes:   Frame lengths and widths are fixed by the device family.
package lmrl_pkg;
  localparam int unsigned OUT_COUNT     = 40;
  localparam int unsigned RAM_ROWS      = 8;
  localparam int unsigned RAM_WIDTH     = 40;
  localparam int unsigned ROW_W         = 3;
  localparam int unsigned FRAME_ROWCOL  = 40;
  localparam int unsigned FRAME_COLONLY = 48;
  localparam int unsigned ADDR_COLONLY  = 8;
  localparam int unsigned SHIFT_W       = 48;
  localparam int unsigned MUX_DEFAULT   = 8;
  localparam int unsigned ENTRY_W       = RAM_WIDTH + RAM_ROWS;
  localparam int unsigned BUF_DEPTH     = 2;
endpackage

/* File: src/lmrl_fifo.sv */
// Purpose: Small ready/valid buffer for captured display words.
// Assumes: Single clock; DEPTH of at least two.
// Notes:   Full and empty are exact; in_ready falls only when every entry is held.
`timescale 1ns/100ps
module lmrl_fifo #(
  parameter int unsigned W     = 48,
  parameter int unsigned DEPTH = 2
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem [DEPTH];
  logic [W-1:0]  next_mem [DEPTH];
  logic [PW-1:0] wp, next_wp, rp, next_rp;
  logic [CW-1:0] cnt, next_cnt;
  logic          push, pop;

  assign in_ready  = (cnt != CW'(DEPTH));
  assign out_valid = (cnt != '0);
  assign out_data  = mem[rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_mem = mem;
    next_wp  = wp;
    next_rp  = rp;
    next_cnt = cnt;
    if (push) begin
      next_mem[wp] = in_data;
      next_wp      = (wp == PW'(DEPTH - 1)) ? '0 : wp + 1'b1;
    end
    if (pop) begin
      next_rp = (rp == PW'(DEPTH - 1)) ? '0 : rp + 1'b1;
    end
    if (push && !pop) begin
      next_cnt = cnt + 1'b1;
    end else if (pop && !push) begin
      next_cnt = cnt - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end else begin
      mem <= next_mem;
      wp  <= next_wp;
      rp  <= next_rp;
      cnt <= next_cnt;
    end
  end
endmodule

/* File: src/lmrl_ram.sv */
// Purpose: Display RAM, one word per row, with a per-row write enable mask.
// Assumes: Several rows may be written with the same word in one cycle.
// Notes:   Read data come out of a register, one cycle after the address.
`timescale 1ns/100ps
module lmrl_ram #(
  parameter int unsigned ROWS  = 8,
  parameter int unsigned WIDTH = 40
) (
  input  wire logic                    clk,
  input  wire logic                    rstn,
  input  wire logic [ROWS-1:0]         we_mask,
  input  wire logic [WIDTH-1:0]        wdata,
  input  wire logic [$clog2(ROWS)-1:0] raddr,
  output logic [WIDTH-1:0]             rdata
);
  logic [WIDTH-1:0] mem [ROWS];
  logic [WIDTH-1:0] next_mem [ROWS];
  logic [WIDTH-1:0] next_rdata;

  always_comb begin
    next_mem   = mem;
    next_rdata = mem[raddr];
    for (int r = 0; r < ROWS; r++) begin
      if (we_mask[r]) begin
        next_mem[r] = wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int r = 0; r < ROWS; r++) begin
        mem[r] <= '0;
      end
      rdata <= '0;
    end else begin
      mem   <= next_mem;
      rdata <= next_rdata;
    end
  end
endmodule

/* File: src/lmrl_loader.sv */
// Purpose: Serial display RAM loader, cascade output and multiplexed pin mapper.
// Assumes: The serial clock stands still around strobe pulses, as the host keeps
//          a gap of at least 200 ns between strobe fall and the next clock fall.
// Notes:   Pin outputs are logic polarity levels; analog bias is outside.
//
// Contract
// - Row/column mode: 40-bit transfer, column data then n address bits, one per row.
// - Column-only mode: 48-bit transfer, 40 column bits then 8 address bits.
// - Each set address bit write-enables its own RAM row, bit 1 is row 1.
// - Several set address bits write the same column word into all those rows.
// - While strobe is high, the row scan is held at row 1.
// - Any RAM write restarts the picture scan from row 1.
// - Row/column mode: lowest n pins are rows, the rest are columns.
// - Column-only mode: all 40 pins are columns 1 to 40, no rows.
// - Frame input is the polarity reference for row and column waveforms.
// - Serial input shifts on falling clock edge; serial output changes on rising.
// - Serial output repeats input delayed by 40 or 48 clocks, per mode.
// - Strobe fall copies column data into enabled rows; zero address writes nothing.
`timescale 1ns/100ps
module lmrl_loader #(
  parameter int unsigned MUX_N = lmrl_pkg::MUX_DEFAULT
) (
  input  wire logic                          clk,
  input  wire logic                          rstn,
  input  wire logic                          serial_clk,
  input  wire logic                          serial_in,
  output logic                               serial_out,
  input  wire logic                          write_strobe,
  input  wire logic                          frame_polarity_in,
  input  wire logic                          col_only_n,
  output logic                               load_ready,
  output logic [lmrl_pkg::OUT_COUNT-1:0]     lcd_drive_outputs,
  output logic [lmrl_pkg::OUT_COUNT-1:0]     lcd_row_select
);
  localparam logic [lmrl_pkg::RAM_ROWS-1:0] ROW_MASK =
    lmrl_pkg::RAM_ROWS'((9'h001 << MUX_N) - 9'h001);

  // Serial clock domain.
  logic [lmrl_pkg::SHIFT_W-1:0] shift, next_shift;
  logic                         scol_m, scol_s;
  logic                         next_serial_out;
  // Falls since reset, saturating at one wide frame. The cascade checks use it
  // to wait until every sample that they look back at was taken after reset.
  logic [5:0]                   fall_cnt, next_fall_cnt;

  always_comb begin
    next_shift    = {shift[lmrl_pkg::SHIFT_W-2:0], serial_in};
    next_fall_cnt = fall_cnt;
    if (fall_cnt != 6'(lmrl_pkg::FRAME_COLONLY)) begin
      next_fall_cnt = fall_cnt + 6'h01;
    end
  end

  always_ff @(negedge serial_clk or negedge rstn) begin
    if (!rstn) begin
      shift    <= '0;
      scol_m   <= 1'b0;
      scol_s   <= 1'b0;
      fall_cnt <= '0;
    end else begin
      shift    <= next_shift;
      scol_m   <= ~col_only_n;
      scol_s   <= scol_m;
      fall_cnt <= next_fall_cnt;
    end
  end

  always_comb begin
    if (scol_s) begin
      next_serial_out = shift[lmrl_pkg::FRAME_COLONLY-1];
    end else begin
      next_serial_out = shift[lmrl_pkg::FRAME_ROWCOL-1];
    end
  end

  always_ff @(posedge serial_clk or negedge rstn) begin
    if (!rstn) begin
      serial_out <= 1'b0;
    end else begin
      serial_out <= next_serial_out;
    end
  end

  // System clock domain: pin synchronisers.
  logic str_m, str_s, str_q;
  logic fr_m, fr_s, fr_q;
  logic col_m, col_s;
  // The frame pin may idle high, so its edge detector stays blind until the
  // synchroniser holds the pin level; otherwise reset would fake a frame edge.
  logic [2:0] fr_arm;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      str_m <= 1'b0;
      str_s <= 1'b0;
      str_q <= 1'b0;
      fr_m  <= 1'b0;
      fr_s  <= 1'b0;
      fr_q  <= 1'b0;
      col_m <= 1'b0;
      col_s <= 1'b0;
      fr_arm <= '0;
    end else begin
      str_m <= write_strobe;
      str_s <= str_m;
      str_q <= str_s;
      fr_m  <= frame_polarity_in;
      fr_s  <= fr_m;
      fr_q  <= fr_s;
      col_m <= ~col_only_n;
      col_s <= col_m;
      fr_arm <= {fr_arm[1:0], 1'b1};
    end
  end

  logic str_fall, fr_rise;
  assign str_fall = str_q && !str_s;
  assign fr_rise  = fr_s && !fr_q && fr_arm[2];

  // Capture of the shift register at strobe fall.
  // The shift register is read here across domains as a quasi-static word: the
  // serial clock is idle from before the strobe rises until well after the
  // synchronised fall has been seen, so every bit is long settled.
  logic [lmrl_pkg::RAM_WIDTH-1:0] cap_cols;
  logic [lmrl_pkg::RAM_ROWS-1:0]  cap_mask;

  always_comb begin
    cap_cols = '0;
    cap_mask = '0;
    if (col_s) begin
      cap_mask = shift[lmrl_pkg::ADDR_COLONLY-1:0];
      cap_cols = shift[lmrl_pkg::FRAME_COLONLY-1:lmrl_pkg::ADDR_COLONLY];
    end else begin
      cap_mask = shift[lmrl_pkg::RAM_ROWS-1:0] & ROW_MASK;
      for (int j = 0; j < lmrl_pkg::RAM_WIDTH; j++) begin
        if (j < lmrl_pkg::FRAME_ROWCOL - MUX_N) begin
          cap_cols[j] = shift[MUX_N + j];
        end
      end
    end
  end

  // A captured word waits here until the buffer takes it.
  logic                         pend_valid, next_pend_valid;
  logic [lmrl_pkg::ENTRY_W-1:0] pend_word, next_pend_word;
  logic                         buf_in_ready;
  logic                         buf_out_valid;
  logic [lmrl_pkg::ENTRY_W-1:0] buf_out_word;
  logic                         drain_ready;
  logic                         next_load_ready;

  always_comb begin
    next_pend_valid = pend_valid;
    next_pend_word  = pend_word;
    if (pend_valid && buf_in_ready) begin
      next_pend_valid = 1'b0;
    end
    if (str_fall && cap_mask != '0) begin
      next_pend_valid = 1'b1;
      next_pend_word  = {cap_cols, cap_mask};
    end
    next_load_ready = buf_in_ready && !next_pend_valid;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pend_valid <= 1'b0;
      pend_word  <= '0;
      load_ready <= 1'b1;
    end else begin
      pend_valid <= next_pend_valid;
      pend_word  <= next_pend_word;
      load_ready <= next_load_ready;
    end
  end

  // The RAM side holds off while a strobe is high, so a word already buffered waits
  // out a long strobe; the host sees load_ready fall while a captured word is pending.
  assign drain_ready = !str_s;

  lmrl_fifo #(
    .W     (lmrl_pkg::ENTRY_W),
    .DEPTH (lmrl_pkg::BUF_DEPTH)
  ) u_buf (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (pend_valid),
    .in_ready  (buf_in_ready),
    .in_data   (pend_word),
    .out_valid (buf_out_valid),
    .out_ready (drain_ready),
    .out_data  (buf_out_word)
  );

  logic                          ram_write;
  logic [lmrl_pkg::RAM_ROWS-1:0] we_mask;
  assign ram_write = buf_out_valid && drain_ready;
  assign we_mask   = ram_write ? buf_out_word[lmrl_pkg::RAM_ROWS-1:0] : '0;

  // Row scan.
  logic [lmrl_pkg::ROW_W-1:0]     row, next_row, row_d;
  logic [lmrl_pkg::RAM_WIDTH-1:0] row_word;

  always_comb begin
    next_row = row;
    if (str_s) begin
      next_row = '0;
    end else if (ram_write) begin
      next_row = '0;
    end else if (fr_rise) begin
      if (row == lmrl_pkg::ROW_W'(MUX_N - 1)) begin
        next_row = '0;
      end else begin
        next_row = row + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      row   <= '0;
      row_d <= '0;
    end else begin
      row   <= next_row;
      row_d <= row;
    end
  end

  lmrl_ram #(
    .ROWS  (lmrl_pkg::RAM_ROWS),
    .WIDTH (lmrl_pkg::RAM_WIDTH)
  ) u_ram (
    .clk     (clk),
    .rstn    (rstn),
    .we_mask (we_mask),
    .wdata   (buf_out_word[lmrl_pkg::ENTRY_W-1:lmrl_pkg::RAM_ROWS]),
    .raddr   (row),
    .rdata   (row_word)
  );

  // Pin mapping. A column pin follows its pixel bit against the frame level, a
  // selected row pin takes the opposite level, so an on pixel sees full swing.
  logic [lmrl_pkg::OUT_COUNT-1:0] next_drive, next_rowsel;

  always_comb begin
    next_drive  = '0;
    next_rowsel = '0;
    for (int i = 0; i < lmrl_pkg::OUT_COUNT; i++) begin
      if (!col_s && i < MUX_N) begin
        next_rowsel[i] = 1'b1;
        next_drive[i]  = (row_d == lmrl_pkg::ROW_W'(i)) ^ ~fr_s;
      end else if (col_s) begin
        next_drive[i] = row_word[i] ^ fr_s;
      end else begin
        next_drive[i] = row_word[i - MUX_N] ^ fr_s;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lcd_drive_outputs <= '0;
      lcd_row_select    <= '0;
    end else begin
      lcd_drive_outputs <= next_drive;
      lcd_row_select    <= next_rowsel;
    end
  end

  // Checks.
  sequence s_strobe_fall;
    str_q && !str_s;
  endsequence

  sequence s_word_written;
    ram_write;
  endsequence

  a_strobe_holds_row: assert property (@(posedge clk) disable iff (!rstn)
    str_s |=> row == '0)
    else $error("Row scan left row 1 while strobe high.");

  a_write_restarts_scan: assert property (@(posedge clk) disable iff (!rstn)
    s_word_written |=> row == '0 ##1 row_d == '0)
    else $error("Scan not restarted after RAM write.");

  a_zero_addr_skips: assert property (@(posedge clk) disable iff (!rstn)
    s_strobe_fall and (cap_mask == '0) |=> !pend_valid || $past(pend_valid))
    else $error("Zero address word was queued for writing.");

  a_mask_writes_rows: assert property (@(posedge clk) disable iff (!rstn)
    s_word_written |=> u_ram.mem[0] == ($past(we_mask[0]) ? $past(buf_out_word[47:8])
                                                          : $past(u_ram.mem[0])))
    else $error("Row 1 write does not follow its address bit.");

  a_stall_on_strobe: assert property (@(posedge clk) disable iff (!rstn)
    s_strobe_fall ##1 pend_valid |-> ##[1:8] !pend_valid || !buf_in_ready)
    else $error("Pending word neither accepted nor stalled.");

  a_row_pins_count: assert property (@(posedge clk) disable iff (!rstn)
    !col_s [*2] |=> lcd_row_select == lmrl_pkg::OUT_COUNT'(ROW_MASK))
    else $error("Row pin count does not match the multiplex number.");

  a_col_only_pins: assert property (@(posedge clk) disable iff (!rstn)
    col_s [*2] |=> lcd_row_select == '0)
    else $error("Row pins produced in column-only mode.");

  a_frame_polarity: assert property (@(posedge clk) disable iff (!rstn)
    col_s |=> lcd_drive_outputs[0] == ($past(row_word[0]) ^ $past(fr_s)))
    else $error("Column pin ignores the frame polarity.");

  a_scan_advances: assert property (@(posedge clk) disable iff (!rstn)
    fr_rise && !str_s && !ram_write && row != lmrl_pkg::ROW_W'(MUX_N - 1)
    |=> row == $past(row) + 1'b1)
    else $error("Row scan did not advance on the frame edge.");

  // The cascade output is compared with the bit that entered forty or forty-eight
  // falls earlier. The fall counter keeps the look-back from reaching across a
  // reset, where the history holds words that the register no longer has.
  a_serial_delay: assert property (@(negedge serial_clk) disable iff (!rstn)
    !scol_s && fall_cnt >= 6'(lmrl_pkg::FRAME_ROWCOL) |-> serial_out == $past(shift[0], 39))
    else $error("Cascade output is not forty clocks behind the input.");

  a_serial_delay_wide: assert property (@(negedge serial_clk) disable iff (!rstn)
    scol_s && fall_cnt == 6'(lmrl_pkg::FRAME_COLONLY) |-> serial_out == $past(shift[0], 47))
    else $error("Cascade output is not forty-eight clocks behind the input.");

  a_mask_last_row: assert property (@(posedge clk) disable iff (!rstn)
    s_word_written |=> u_ram.mem[7] == ($past(we_mask[7]) ? $past(buf_out_word[47:8])
                                                          : $past(u_ram.mem[7])))
    else $error("Row 8 write does not follow its address bit.");

  a_rows_same_word: assert property (@(posedge clk) disable iff (!rstn)
    s_word_written ##0 (we_mask[1] && we_mask[2]) |=> u_ram.mem[1] == u_ram.mem[2])
    else $error("Rows written together do not hold the same word.");

  a_full_drops_ready: assert property (@(posedge clk) disable iff (!rstn)
    !buf_in_ready |=> !load_ready)
    else $error("Load ready stayed high with the buffer full.");
endmodule

/* File: sim/lmrl_host.sv */
// Purpose: Host model that shifts display frames into the loader and strobes them.
// Assumes: Link clock period of 64 ns; the link clock idles high between frames.
// Notes:   Every bit sent is queued so the bench can check the cascade output.
`timescale 1ns/100ps
module lmrl_host (
  output logic serial_clk,
  output logic serial_in,
  output logic write_strobe
);
  logic sent[$];

  initial begin
    serial_clk   = 1'b1;
    serial_in    = 1'b0;
    write_strobe = 1'b0;
  end

  task automatic shift(input logic [47:0] w, input int len);
    for (int i = len - 1; i >= 0; i--) begin
      serial_in = w[i];
      #32 serial_clk = 1'b0;
      #32 serial_clk = 1'b1;
      sent.push_back(w[i]);
    end
    // A released line must not go on looking like the last bit.
    serial_in = ~w[0];
  endtask

  task automatic strobe(input int width_ns);
    #20 write_strobe = 1'b1;
    #(width_ns) write_strobe = 1'b0;
    // The link clock stays still well past the strobe fall.
    #220;
  endtask
endmodule

/* File: sim/testbench.sv */
// Purpose: Self-checking bench for the serial display RAM loader.
// Assumes: Eight-way multiplex; the frame level is held while pins are compared.
// Notes:   Pin expectations are queued by the driver and checked by a monitor.
`timescale 1ns/100ps
module testbench;
  localparam int unsigned MUX = 8;
  logic                             clk = 1'b0;
  logic                             rstn = 1'b1;
  logic                             frame_polarity_in;
  logic                             col_only_n;
  logic                             serial_clk;
  logic                             serial_in;
  logic                             write_strobe;
  logic                             serial_out;
  logic                             load_ready;
  logic [lmrl_pkg::OUT_COUNT-1:0]   lcd_drive_outputs;
  logic [lmrl_pkg::OUT_COUNT-1:0]   lcd_row_select;
  logic [39:0]                      exp_q[$];
  logic [47:0]                      w0;
  logic [47:0]                      w1;
  logic [31:0]                      seed = 32'h0000003c;
  int                               flen = 40;
  int                               num_errors = 0;
  int                               comparisons = 0;
  event                             look;

  always #10 clk = ~clk;

  lmrl_host host (
    .serial_clk   (serial_clk),
    .serial_in    (serial_in),
    .write_strobe (write_strobe)
  );

  lmrl_loader #(.MUX_N(MUX)) DUT (
    .clk               (clk),
    .rstn              (rstn),
    .serial_clk        (serial_clk),
    .serial_in         (serial_in),
    .serial_out        (serial_out),
    .write_strobe      (write_strobe),
    .frame_polarity_in (frame_polarity_in),
    .col_only_n        (col_only_n),
    .load_ready        (load_ready),
    .lcd_drive_outputs (lcd_drive_outputs),
    .lcd_row_select    (lcd_row_select)
  );

  function automatic logic [31:0] step();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [47:0] rnd();
    logic [63:0] t;
    t = {step(), step()};
    return t[47:0];
  endfunction

  function automatic logic [39:0] pins(input logic [39:0] d, input int row, input logic fr);
    logic [39:0] p;
    p = d ^ {40{fr}};
    if (col_only_n) begin
      for (int i = 0; i < MUX; i++) begin
        p[i] = (i == row) ^ ~fr;
      end
    end
    return p;
  endfunction

  task automatic check_word(input string what, input logic [39:0] e, input logic [39:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic check_bit(input string what, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %b seen %b", what, e, g);
    end
  endtask

  task automatic summarize();
    $display("TB: %0d comparisons, %0d errors", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Twenty cycles covers the strobe sync, buffer, RAM and pin register path.
  task automatic expect_pins(input logic [39:0] d, input int row);
    repeat (20) @(posedge clk);
    #1;
    exp_q.push_back(pins(d, row, frame_polarity_in));
    -> look;
  endtask

  task automatic set_fr(input logic v);
    @(posedge clk) frame_polarity_in <= v;
    repeat (6) @(posedge clk);
  endtask

  task automatic load(input logic [47:0] w);
    host.shift(w, flen);
    host.strobe(200);
  endtask

  task automatic do_reset(input logic col);
    @(posedge clk);
    rstn       <= 1'b0;
    col_only_n <= col;
    host.sent.delete();
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (5) @(posedge clk);
  endtask

  always @(look) begin
    check_word("pins", exp_q.pop_front(), lcd_drive_outputs);
  end

  always @(negedge serial_clk) begin
    if (host.sent.size() >= flen) begin
      check_bit("serial_out", host.sent.pop_front(), serial_out);
    end
  end

  initial begin
    frame_polarity_in = 1'b1;
    col_only_n        = 1'b1;
    // The link-side flops have an idle clock, so reset must reach them as an edge.
    #1 rstn = 1'b0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (5) @(posedge clk);
    check_word("row_select", 40'h00000000ff, lcd_row_select);
    check_bit("load_ready", 1'b1, load_ready);
    w0 = rnd();
    w1 = rnd();
    load({w1[47:8], 8'h06});
    load({w0[47:8], 8'h01});
    load({~w0[47:8], 8'h00});
    expect_pins(w0[39:0], 0);
    set_fr(1'b0);
    expect_pins(w0[39:0], 0);
    set_fr(1'b1);
    expect_pins(w1[39:0], 1);
    set_fr(1'b0);
    set_fr(1'b1);
    expect_pins(w1[39:0], 2);
    $display("TB: test row_column done");
    host.shift({w1[47:8], 8'h00}, flen);
    fork
      host.strobe(2000);
      begin
        #300;
        set_fr(1'b0);
        set_fr(1'b1);
      end
    join
    expect_pins(w0[39:0], 0);
    $display("TB: test strobe_hold done");
    flen = 48;
    do_reset(1'b0);
    check_word("row_select", 40'h0000000000, lcd_row_select);
    load({w0[39:0], 8'h01});
    load({w1[39:0], 8'h80});
    expect_pins(w0[39:0], 0);
    $display("TB: test column_only done");
    summarize();
  end

  // The tests need about 24 us; over sixteen times that means a hang.
  initial begin
    #400000;
    num_errors++;
    summarize();
  end
endmodule
